// *** include/timer_counter_pwm_unit_pkg.sv ***
// Purpose: Shared constants for the timer, counter and pulse-width unit
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz clock
// Notes:   Offsets are byte addresses of aligned words
package timer_counter_pwm_unit_pkg;
   localparam int unsigned CNT_W      = 16;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned CMP_NUM    = 2;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_PERIOD  = 8'h04;
   localparam logic [7:0] OFS_CMP0    = 8'h08;
   localparam logic [7:0] OFS_CMP1    = 8'h0c;
   localparam logic [7:0] OFS_DEAD    = 8'h10;
   localparam logic [7:0] OFS_COUNT   = 8'h14;
   localparam logic [7:0] OFS_CAPTURE = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1c;
   // Control register fields
   localparam int unsigned CTRL_RUN      = 0;
   localparam int unsigned CTRL_ONESHOT  = 1;
   localparam int unsigned CTRL_CAP_RISE = 2;
   localparam int unsigned CTRL_KILL_TRU = 3;
   localparam int unsigned CTRL_KILL_CMP = 4;
   localparam int unsigned CTRL_SW_CAP   = 5;
   localparam int unsigned CTRL_W        = 6;
   // Status register fields
   localparam int unsigned STAT_RUN  = 0;
   localparam int unsigned STAT_KILL = 1;
   localparam int unsigned STAT_CAP  = 2;
   localparam int unsigned STAT_TC   = 3;
   localparam int unsigned STAT_PWM  = 4;
   // Reset values and counter step
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [15:0] CMP_RST    = 16'h0000;
   localparam logic [15:0] DEAD_RST   = 16'h0000;
   localparam logic [15:0] CNT_RST    = 16'h0000;
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** rtl/deadband_pair.sv ***
// Purpose: True and complementary output pair with dead-band delay
// Assumes: One clock, synchronous active-low reset
// Notes:   Each output rises only after its input held for dead cycles
`timescale 1ns/1ns
module deadband_pair #(
   parameter int unsigned W = 16
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         pwm_in,
   input  wire logic [W-1:0] dead,
   output logic              out_true,
   output logic              out_comp
);
   logic         last_reg;
   logic [W-1:0] delay_reg;

   //----------------------------------------
   // Edge tracking and delay count
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_reg  <= 1'b0;
         delay_reg <= '0;
      end else begin
         last_reg <= pwm_in;
         if (last_reg != pwm_in) begin
            delay_reg <= dead;
         end else if (delay_reg != '0) begin
            delay_reg <= delay_reg - 1'b1;
         end
      end
   end

   // Both low during the gap so the pair never switches together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_true <= 1'b0;
         out_comp <= 1'b0;
      end else if (last_reg != pwm_in || delay_reg > 1) begin
         out_true <= 1'b0;
         out_comp <= 1'b0;
      end else begin
         out_true <= last_reg;
         out_comp <= ~last_reg;
      end
   end
endmodule

// *** rtl/timer_counter_pwm_unit.sv ***
// Purpose: 16-bit timer, counter and PWM unit with capture and kill
// Assumes: AXI4-Lite slave, 100 MHz aclk, synchronous active-low reset
// Notes:   cap_pin and kill_pin are asynchronous and synchronised here
//
// Function
// - One 16-bit counter whose period is set by software.
// - A capture event copies the counter into the capture register.
// - On counter equal period the counter stops or reloads as configured.
// - Counter compared with compare values gives the PWM duty waveform.
// - True and complementary outputs are separated by a programmable dead band.
// - While kill is asserted the outputs take their preset safe levels, three clocks after kill_pin (two synchroniser stages plus the output register).
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module timer_counter_pwm_unit #(
   parameter int unsigned CNT_W = timer_counter_pwm_unit_pkg::CNT_W
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cap_pin,
   input  wire logic        kill_pin,
   output logic             pwm_true,
   output logic             pwm_comp,
   output logic             tc_pulse
);
   logic [timer_counter_pwm_unit_pkg::CTRL_W-1:0] ctrl_reg;
   logic [CNT_W-1:0]             period_reg;
   logic [CNT_W-1:0]             cmp_reg [timer_counter_pwm_unit_pkg::CMP_NUM];
   logic [CNT_W-1:0]             dead_reg;
   logic [CNT_W-1:0]             count_reg;
   logic [CNT_W-1:0]             capture_reg;
   logic                         cap_flag_reg;
   logic                         running_reg;
   logic [1:0]                   cap_sync_reg;
   logic [1:0]                   kill_sync_reg;
   logic                         cap_last_reg;
   logic                         pwm_reg;
   logic                         db_true;
   logic                         db_comp;
   logic [7:0]                   awaddr_reg;
   logic [31:0]                  wdata_reg;
   logic [3:0]                   wstrb_reg;
   logic                         aw_full_reg;
   logic                         w_full_reg;
   logic                         wr_go;
   logic                         sw_cap_req;
   logic                         cap_event;
   logic                         kill_now;
   logic                         at_period;
   localparam int unsigned CTRL_W = timer_counter_pwm_unit_pkg::CTRL_W;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   //----------------------------------------
   // Pin synchronisers
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_sync_reg  <= 2'b00;
         kill_sync_reg <= 2'b00;
         cap_last_reg  <= 1'b0;
      end else begin
         cap_sync_reg  <= {cap_sync_reg[0], cap_pin};
         kill_sync_reg <= {kill_sync_reg[0], kill_pin};
         cap_last_reg  <= cap_sync_reg[1];
      end
   end

   assign kill_now   = kill_sync_reg[1];
   assign sw_cap_req = wr_go && awaddr_reg == timer_counter_pwm_unit_pkg::OFS_CTRL &&
                       wstrb_reg[0] && wdata_reg[timer_counter_pwm_unit_pkg::CTRL_SW_CAP];
   assign cap_event  = (ctrl_reg[timer_counter_pwm_unit_pkg::CTRL_CAP_RISE] && cap_sync_reg[1] && !cap_last_reg)
                       || sw_cap_req;
   assign at_period  = count_reg == period_reg;

   //----------------------------------------
   // AXI4-Lite write channel
   //----------------------------------------
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= timer_counter_pwm_unit_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_full_reg && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_reg && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg > timer_counter_pwm_unit_pkg::OFS_DEAD || awaddr_reg[1:0] != 2'b00) begin
               s_axi_bresp <= timer_counter_pwm_unit_pkg::RESP_SLVERR;
            end else begin
               s_axi_bresp <= timer_counter_pwm_unit_pkg::RESP_OKAY;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   //----------------------------------------
   // Configuration registers
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg   <= '0;
         period_reg <= timer_counter_pwm_unit_pkg::PERIOD_RST;
         cmp_reg[0] <= timer_counter_pwm_unit_pkg::CMP_RST;
         cmp_reg[1] <= timer_counter_pwm_unit_pkg::CMP_RST;
         dead_reg   <= timer_counter_pwm_unit_pkg::DEAD_RST;
      end else if (wr_go) begin
         if (awaddr_reg == timer_counter_pwm_unit_pkg::OFS_CTRL) begin
            ctrl_reg <= CTRL_W'(merge(32'(ctrl_reg), wdata_reg, wstrb_reg));
         end else if (awaddr_reg == timer_counter_pwm_unit_pkg::OFS_PERIOD) begin
            period_reg <= CNT_W'(merge(32'(period_reg), wdata_reg, wstrb_reg));
         end else if (awaddr_reg == timer_counter_pwm_unit_pkg::OFS_CMP0) begin
            cmp_reg[0] <= CNT_W'(merge(32'(cmp_reg[0]), wdata_reg, wstrb_reg));
         end else if (awaddr_reg == timer_counter_pwm_unit_pkg::OFS_CMP1) begin
            cmp_reg[1] <= CNT_W'(merge(32'(cmp_reg[1]), wdata_reg, wstrb_reg));
         end else if (awaddr_reg == timer_counter_pwm_unit_pkg::OFS_DEAD) begin
            dead_reg <= CNT_W'(merge(32'(dead_reg), wdata_reg, wstrb_reg));
         end
      end
   end

   //----------------------------------------
   // Counter, period match and capture
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg   <= timer_counter_pwm_unit_pkg::CNT_RST;
         running_reg <= 1'b0;
         tc_pulse    <= 1'b0;
      end else begin
         tc_pulse <= 1'b0;
         if (!ctrl_reg[timer_counter_pwm_unit_pkg::CTRL_RUN]) begin
            running_reg <= 1'b0;
            count_reg   <= timer_counter_pwm_unit_pkg::CNT_RST;
         end else if (!running_reg) begin
            // Run bit rising restarts a one-shot; stopped state holds otherwise
            running_reg <= (count_reg == timer_counter_pwm_unit_pkg::CNT_RST);
         end else if (at_period) begin
            tc_pulse  <= 1'b1;
            count_reg <= timer_counter_pwm_unit_pkg::CNT_RST;
            if (ctrl_reg[timer_counter_pwm_unit_pkg::CTRL_ONESHOT]) begin
               running_reg <= 1'b0;
               count_reg   <= count_reg;
            end
         end else begin
            count_reg <= count_reg + timer_counter_pwm_unit_pkg::CNT_ONE;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_reg  <= timer_counter_pwm_unit_pkg::CNT_RST;
         cap_flag_reg <= 1'b0;
      end else if (cap_event) begin
         capture_reg  <= count_reg;
         cap_flag_reg <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_CAPTURE) begin
         cap_flag_reg <= 1'b0;
      end
   end

   //----------------------------------------
   // Compare, dead band and kill
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_reg <= 1'b0;
      end else begin
         // High from compare 0 up to, not including, compare 1
         pwm_reg <= running_reg && count_reg >= cmp_reg[0] && count_reg < cmp_reg[1];
      end
   end

   deadband_pair #(
      .W (CNT_W)
   ) u_dead (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pwm_in   (pwm_reg),
      .dead     (dead_reg),
      .out_true (db_true),
      .out_comp (db_comp)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_true <= 1'b0;
         pwm_comp <= 1'b0;
      end else if (kill_now) begin
         pwm_true <= ctrl_reg[timer_counter_pwm_unit_pkg::CTRL_KILL_TRU];
         pwm_comp <= ctrl_reg[timer_counter_pwm_unit_pkg::CTRL_KILL_CMP];
      end else begin
         pwm_true <= db_true;
         pwm_comp <= db_comp;
      end
   end

   //----------------------------------------
   // AXI4-Lite read channel
   //----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= timer_counter_pwm_unit_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= timer_counter_pwm_unit_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_CTRL) begin
               s_axi_rdata <= 32'(ctrl_reg);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_PERIOD) begin
               s_axi_rdata <= 32'(period_reg);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_CMP0) begin
               s_axi_rdata <= 32'(cmp_reg[0]);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_CMP1) begin
               s_axi_rdata <= 32'(cmp_reg[1]);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_DEAD) begin
               s_axi_rdata <= 32'(dead_reg);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_COUNT) begin
               s_axi_rdata <= 32'(count_reg);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_CAPTURE) begin
               s_axi_rdata <= 32'(capture_reg);
            end else if (s_axi_araddr == timer_counter_pwm_unit_pkg::OFS_STATUS) begin
               s_axi_rdata[timer_counter_pwm_unit_pkg::STAT_RUN]  <= running_reg;
               s_axi_rdata[timer_counter_pwm_unit_pkg::STAT_KILL] <= kill_now;
               s_axi_rdata[timer_counter_pwm_unit_pkg::STAT_CAP]  <= cap_flag_reg;
               s_axi_rdata[timer_counter_pwm_unit_pkg::STAT_TC]   <= at_period;
               s_axi_rdata[timer_counter_pwm_unit_pkg::STAT_PWM]  <= pwm_reg;
            end else begin
               s_axi_rresp <= timer_counter_pwm_unit_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// *** test/timer_counter_pwm_unit_assertions.sv ***
// Purpose: Port-level checks for the timer counter pwm unit
// Assumes: One clock; the two kill levels are never both high
// Notes:   Bound to the top module
`timescale 1ns/1ns
module timer_counter_pwm_unit_checker #(
   parameter int unsigned CNT_W = 16
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        kill_pin,
   input wire logic        pwm_true,
   input wire logic        pwm_comp
);
   // ---------------------------------------------
   // Kill run lengths, saturating at seven
   // ---------------------------------------------
   logic [2:0] on_cnt;
   logic [2:0] off_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn || !kill_pin) begin
         on_cnt <= 3'h0;
      end else if (on_cnt != 3'h7) begin
         on_cnt <= on_cnt + 3'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || kill_pin) begin
         off_cnt <= 3'h0;
      end else if (off_cnt != 3'h7) begin
         off_cnt <= off_cnt + 3'h1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   no_overlap_a: assert property (off_cnt >= 3'h5 |-> !(pwm_true && pwm_comp))
      else $error("true and complementary outputs high together");
   kill_hold_a: assert property (on_cnt >= 3'h5 |-> $stable(pwm_true) && $stable(pwm_comp))
      else $error("outputs moved while kill held");
   write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read data late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready held");
   ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("read address ready held");
endmodule

bind timer_counter_pwm_unit timer_counter_pwm_unit_checker #(.CNT_W(CNT_W)) checker_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .kill_pin(kill_pin), .pwm_true(pwm_true), .pwm_comp(pwm_comp)
);

// *** test/gate_load.sv ***
// Purpose: Gate driver load with overcurrent trip and event source
// Assumes: Requests arrive on the rising clock edge
// Notes:   Overlap flag is sticky until reset
`timescale 1ns/1ns
module gate_load (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pwm_true,
   input  wire logic pwm_comp,
   input  wire logic trip,
   input  wire logic strike,
   output logic      kill_pin,
   output logic      cap_pin,
   output logic      overlap_seen
);
   always_ff @(posedge aclk) begin
      kill_pin <= trip;
      cap_pin  <= strike;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overlap_seen <= 1'b0;
      end else if (pwm_true && pwm_comp) begin
         overlap_seen <= 1'b1;
      end
   end
endmodule

// *** test/timer_counter_pwm_unit_test.sv ***
// Purpose: Register, waveform, kill and capture tests of the unit
// Assumes: Period 9, compare window 2 to 6
// Notes:   Ready signals are raised only after valid is seen
`timescale 1ns/1ns
module timer_counter_pwm_unit_test;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, cap_pin, kill_pin, pwm_true, pwm_comp;
   logic        tc_pulse, trip, strike, overlap_seen;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   int          err_count, num_checks;
   logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
   logic [31:0] rst_v [8] = '{32'h0, {16'h0, timer_counter_pwm_unit_pkg::PERIOD_RST}, 32'h0, 32'h0,
                              32'h0, 32'h0, 32'h0, 32'h0};
   timer_counter_pwm_unit timer_counter_pwm_unit_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cap_pin(cap_pin), .kill_pin(kill_pin), .pwm_true(pwm_true), .pwm_comp(pwm_comp),
      .tc_pulse(tc_pulse));
   gate_load gate_load_inst (.aclk(aclk), .aresetn(aresetn), .pwm_true(pwm_true),
      .pwm_comp(pwm_comp), .trip(trip), .strike(strike), .kill_pin(kill_pin),
      .cap_pin(cap_pin), .overlap_seen(overlap_seen));
   always #5 aclk = ~aclk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hang(input int n);
      if (n >= 50) begin
         err_count++;
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int  n;
      logic aw_ok, w_ok;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      while (!(aw_ok && w_ok) && n < 50) begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      hang(n);
      n = 0;
      while (bvalid !== 1'b1 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      hang(n);
      bready <= 1'b1;
      @(posedge aclk);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 50);
      hang(n);
      arvalid <= 1'b0;
      n = 0;
      while (rvalid !== 1'b1 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      hang(n);
      rready <= 1'b1;
      @(posedge aclk);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // Counts output high cycles over one period that follows a terminal count
   task automatic measure(input int et, input int ec);
      int n, t, c;
      n = 0;
      t = 0;
      c = 0;
      do begin
         @(posedge aclk);
         #1;
         n++;
      end while (tc_pulse !== 1'b1 && n < 50);
      hang(n);
      repeat (10) begin
         @(posedge aclk);
         #1;
         t += int'(pwm_true);
         c += int'(pwm_comp);
      end
      chk("tc_spacing", 32'(tc_pulse), 32'h1);
      chk("true_high", 32'(t), 32'(et));
      chk("comp_high", 32'(c), 32'(ec));
   endtask
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trip, strike} = '0;
      {awaddr, araddr, wdata, wstrb, err_count, num_checks} = '0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(ofs[i], d, r);
         chk("reset_value", d, rst_v[i]);
      end
      rd(8'h20, d, r);
      chk("unmapped_resp", 32'(r), 32'(timer_counter_pwm_unit_pkg::RESP_SLVERR));
      chk("unmapped_data", d, 32'h0);
      wr(timer_counter_pwm_unit_pkg::OFS_COUNT, 32'h1234, r);
      chk("ro_resp", 32'(r), 32'(timer_counter_pwm_unit_pkg::RESP_SLVERR));
      wr(timer_counter_pwm_unit_pkg::OFS_PERIOD, 32'h9, r);
      wr(timer_counter_pwm_unit_pkg::OFS_CMP0, 32'h2, r);
      wr(timer_counter_pwm_unit_pkg::OFS_CMP1, 32'h6, r);
      wr(timer_counter_pwm_unit_pkg::OFS_CTRL, 32'h1, r);
      rd(timer_counter_pwm_unit_pkg::OFS_PERIOD, d, r);
      chk("period", d, 32'h9);
      measure(3, 5);
      wr(timer_counter_pwm_unit_pkg::OFS_DEAD, 32'h2, r);
      measure(2, 4);
      wr(timer_counter_pwm_unit_pkg::OFS_CTRL, 32'h9, r);
      trip <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("kill_true", 32'(pwm_true), 32'h1);
      chk("kill_comp", 32'(pwm_comp), 32'h0);
      rd(timer_counter_pwm_unit_pkg::OFS_STATUS, d, r);
      chk("kill_flag", d & 32'h2, 32'h2);
      trip <= 1'b0;
      wr(timer_counter_pwm_unit_pkg::OFS_CTRL, 32'h0, r);
      wr(timer_counter_pwm_unit_pkg::OFS_CTRL, 32'h7, r);
      repeat (20) @(posedge aclk);
      rd(timer_counter_pwm_unit_pkg::OFS_COUNT, d, r);
      chk("oneshot_hold", d, 32'h9);
      strike <= 1'b1;
      repeat (2) @(posedge aclk);
      strike <= 1'b0;
      repeat (6) @(posedge aclk);
      rd(timer_counter_pwm_unit_pkg::OFS_STATUS, d, r);
      chk("cap_flags", d & 32'hc, 32'hc);
      rd(timer_counter_pwm_unit_pkg::OFS_CAPTURE, d, r);
      chk("capture", d, 32'h9);
      chk("overlap", 32'(overlap_seen), 32'h0);
      conclude();
   end
endmodule
